//--- design/uscr_top.sv
// Purpose: system control register of a full-speed USB device controller
// Assumes: status and feature inputs come from logic on clk
// Notes:   one 8-bit control register plus a read-only status word
//
// Overview of operation
// - control register at index 11h, all bits zero after reset.
// - bit 7 set makes interrupt output active-high, clear active-low.
// - bit 6 enables remote wake-up.
// - bit 5 lets the suspend event raise an interrupt.
// - bit 4 lets the bus reset event raise an interrupt.
// - writing 1 to bit 3 holds the device in reset.
// - soft reset write while suspended is ignored unless wake conditions hold.
// - clearing bit 3 releases the device unconfigured, as after hard reset.
// - suspended soft reset wakes only if feature 1, power 0, low-out 0.
// - soft wake acts like remote wake but sends no resume signalling.
// - soft wake works whatever the remote wake enable bit holds.
// - soft wake never sets the remote wake request flag.
// - soft wake starts at once; bit 3 sets only after clocks run.
// - after wake completes bit 3 sets and acts as an awake reset.
// - bit 2 selects level mode, or a two-clock pulse when set.
// - bit 1 globally enables the interrupt output for all sources.
// - bit 0 reserved; written as zero, always reads zero.
`timescale 1ns/1ps
`include "uscr_params.svh"

module uscr_top (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire uscr_pkg::uscr_apb_req_t apb_req,
   output logic                        apb_rsp_pready,
   output logic                        apb_rsp_pslverr,
   output logic [31:0]                 apb_rsp_prdata,
   input  wire logic                   suspended,
   input  wire logic                   clocks_running,
   input  wire logic                   feature_enable_bit,
   input  wire logic                   suspend_power_option,
   input  wire logic                   suspend_low_out_enable,
   input  wire logic                   remote_wake_cmd,
   input  wire logic                   txrx_flag,
   input  wire logic                   sof_flag,
   input  wire logic                   bus_reset_flag,
   input  wire logic                   suspend_flag,
   output logic                        interrupt_out_pin,
   output logic                        device_reset,
   output logic                        remote_wake_enable,
   output logic                        wake_request,
   output logic                        resume_signal,
   output logic                        remote_wake_request_flag
);
   import uscr_pkg::*;

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   logic [7:0]    ctrl_q;
   logic [7:0]    ctrl_d;
   uscr_wake_st_t wk_q;
   uscr_wake_st_t wk_d;
   logic [1:0]    pulse_cnt_q;
   logic [1:0]    pulse_cnt_d;
   logic          src_q;
   logic          irq_act_q;

   // -------------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------------
   wire logic [7:0] idx      = apb_req.paddr[9:2];
   wire logic       aligned  = (apb_req.paddr[1:0] == 2'h0);
   wire logic       hit_ctrl = aligned && (idx == `USCR_CTRL_IDX);
   wire logic       hit_stat = aligned && (idx == `USCR_STAT_IDX);
   wire logic       setup    = apb_req.psel && !apb_req.penable;
   wire logic       access   = apb_req.psel && apb_req.penable &&
                               apb_rsp_pready;
   wire logic       wr_ctrl  = access && apb_req.pwrite && hit_ctrl;
   wire logic [7:0] wdat     = apb_req.pwdata[7:0];

   wire logic [7:0] stat_word = {4'h0, suspended, device_reset,
                                 irq_act_q, (wk_q == WK_WAIT)};
   wire logic [7:0] ctrl_rd   = {ctrl_q[7:1], 1'b0};
   wire logic [31:0] rd_word  = hit_ctrl ? {24'h0, ctrl_rd} :
                                hit_stat ? {24'h0, stat_word} : 32'h0;

   // -------------------------------------------------------------------
   // soft reset and wake decode
   // -------------------------------------------------------------------
   wire logic wake_ok  = feature_enable_bit && !suspend_power_option &&
                         !suspend_low_out_enable;
   // rwe bit deliberately not part of wake_ok
   wire logic srst_wr1 = wr_ctrl && wdat[`USCR_B_SRST];
   wire logic soft_go  = srst_wr1 && suspended && wake_ok &&
                         (wk_q == WK_IDLE);
   wire logic wake_done = (wk_q == WK_WAIT) && clocks_running &&
                          !suspended;
   wire logic remote_go = remote_wake_cmd && ctrl_q[`USCR_B_RWE] &&
                          suspended && (wk_q == WK_IDLE);

   // bit 3 value: suspended writes of 1 never land directly
   wire logic srst_next =
      wake_done                 ? 1'b1 :
      (wr_ctrl && !suspended)   ? wdat[`USCR_B_SRST] :
      (wr_ctrl && !srst_wr1)    ? 1'b0 :
      ctrl_q[`USCR_B_SRST];

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = wdat;
      end
      ctrl_d[`USCR_B_SRST] = srst_next;
      ctrl_d[`USCR_B_RSVD] = 1'b0;
   end

   always_comb begin
      wk_d = wk_q;
      unique case (wk_q)
         WK_IDLE: begin
            if (soft_go) begin
               wk_d = WK_WAIT;
            end
         end
         WK_WAIT: begin
            if (wake_done) begin
               wk_d = WK_IDLE;
            end
         end
         default: begin
            wk_d = WK_IDLE;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // interrupt
   // -------------------------------------------------------------------
   wire logic src_any = txrx_flag || sof_flag ||
                        (bus_reset_flag && ctrl_q[`USCR_B_RIE]) ||
                        (suspend_flag && ctrl_q[`USCR_B_SIE]);
   wire logic src_en  = ctrl_q[`USCR_B_GIE] && src_any;
   wire logic src_rise = src_en && !src_q;

   always_comb begin
      pulse_cnt_d = pulse_cnt_q;
      if (src_rise) begin
         pulse_cnt_d = `USCR_IRQ_PULSE_CYC;
      end else if (pulse_cnt_q != 2'h0) begin
         pulse_cnt_d = pulse_cnt_q - 2'h1;
      end
   end

   // level holds for as long as an enabled source stays set
   wire logic irq_next = ctrl_q[`USCR_B_PULSE] ?
                         (pulse_cnt_d != 2'h0) : src_en;
   // polarity applied at the pin only; firmware owns glitch safety
   wire logic pin_next = ctrl_q[`USCR_B_POL] ? irq_next
                                             : !irq_next;

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q      <= `USCR_CTRL_RST;
         wk_q        <= WK_IDLE;
         pulse_cnt_q <= 2'h0;
         src_q       <= 1'b0;
         irq_act_q   <= 1'b0;
      end else begin
         ctrl_q      <= ctrl_d;
         wk_q        <= wk_d;
         pulse_cnt_q <= pulse_cnt_d;
         src_q       <= src_en;
         irq_act_q   <= irq_next;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         interrupt_out_pin  <= 1'b1;
         device_reset       <= 1'b0;
         remote_wake_enable <= 1'b0;
         wake_request       <= 1'b0;
         resume_signal      <= 1'b0;
         remote_wake_request_flag <= 1'b0;
      end else begin
         interrupt_out_pin  <= pin_next;
         device_reset       <= ctrl_d[`USCR_B_SRST];
         remote_wake_enable <= ctrl_d[`USCR_B_RWE];
         wake_request       <= (wk_d == WK_WAIT) || remote_go;
         resume_signal      <= remote_go;
         remote_wake_request_flag <= remote_go;
      end
   end

   // no wait state: pready is already high in the first access-phase cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         apb_rsp_pready  <= 1'b0;
         apb_rsp_pslverr <= 1'b0;
         apb_rsp_prdata  <= 32'h0;
      end else begin
         apb_rsp_pready  <= setup;
         apb_rsp_pslverr <= setup && !(hit_ctrl || hit_stat);
         apb_rsp_prdata  <= setup ? rd_word : 32'h0;
      end
   end

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_soft_write;
      wr_ctrl && wdat[`USCR_B_SRST] && suspended && wake_ok &&
      (wk_q == WK_IDLE);
   endsequence

   sequence s_waiting;
      (wk_q == WK_WAIT) && !ctrl_q[`USCR_B_SRST];
   endsequence

   AST_READ_CTRL: assert property (
      access && !apb_req.pwrite && hit_ctrl |->
      apb_rsp_prdata[0] == 1'b0 && apb_rsp_prdata[7:1] == ctrl_q[7:1])
      else $error("control read mismatch");

   AST_SUSP_IGNORE: assert property (
      wr_ctrl && wdat[`USCR_B_SRST] && suspended && !wake_ok
      && !wake_done |=> $stable(ctrl_q[`USCR_B_SRST]))
      else $error("suspended soft reset took effect");

   AST_WAKE_START: assert property (
      s_soft_write |=> wake_request && !ctrl_q[`USCR_B_SRST])
      else $error("soft wake did not start");

   AST_WAKE_DEFER: assert property (
      s_waiting ##0 (suspended || !clocks_running) |=>
      !ctrl_q[`USCR_B_SRST])
      else $error("reset bit set before clocks ran");

   AST_WAKE_DONE: assert property (
      s_waiting ##0 clocks_running && !suspended |=>
      ctrl_q[`USCR_B_SRST] ##1 device_reset)
      else $error("reset bit missing after wake");

   AST_NO_RESUME: assert property (
      s_soft_write ##1 s_waiting[*2] |-> !resume_signal)
      else $error("resume signalled on soft wake");

   AST_NO_RWFLAG: assert property (
      (wk_q == WK_WAIT) |-> !remote_wake_request_flag)
      else $error("remote wake flag set on soft wake");

   AST_PULSE_TWO: assert property (
      ctrl_q[`USCR_B_PULSE] && src_rise && $stable(ctrl_q) |=>
      irq_act_q ##1 irq_act_q)
      else $error("pulse shorter than two clocks");

   AST_LEVEL_HOLD: assert property (
      !ctrl_q[`USCR_B_PULSE] && src_en [*3] |=> irq_act_q)
      else $error("level interrupt dropped");

   AST_POLARITY: assert property (
      $stable(ctrl_q[`USCR_B_POL]) |->
      interrupt_out_pin == ($past(ctrl_q[`USCR_B_POL]) ~^ irq_act_q))
      else $error("interrupt pin polarity wrong");

   AST_GIE_OFF: assert property (
      !ctrl_q[`USCR_B_GIE] [*3] |=> !irq_act_q)
      else $error("interrupt with global enable clear");

endmodule : uscr_top

//--- design/uscr_params.svh
// Purpose: offsets, field positions, reset values and counts of the
//          system control block
// Assumes: included by the top module and the bench
// Notes:   printed offsets are register indices; byte address is index*4
`ifndef USCR_PARAMS_SVH
`define USCR_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define USCR_CTRL_IDX      8'h11
`define USCR_STAT_IDX      8'h20

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define USCR_B_POL         7
`define USCR_B_RWE         6
`define USCR_B_SIE         5
`define USCR_B_RIE         4
`define USCR_B_SRST        3
`define USCR_B_PULSE       2
`define USCR_B_GIE         1
`define USCR_B_RSVD        0

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define USCR_CTRL_RST      8'h00
`define USCR_IRQ_PULSE_CYC 2'h2

`endif

//--- design/uscr_pkg.sv
// Purpose: types shared by the system control block
// Assumes: APB with 32-bit data and byte addresses
// Notes:   constants live in uscr_params.svh
package uscr_pkg;

   // -------------------------------------------------------------------
   // bus carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [9:0]  paddr;
      logic [31:0] pwdata;
   } uscr_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } uscr_apb_rsp_t;

   // -------------------------------------------------------------------
   // soft wake sequencer
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      WK_IDLE = 2'b01,
      WK_WAIT = 2'b10
   } uscr_wake_st_t;

endpackage : uscr_pkg

//--- verif/uscr_fw_model.sv
// Purpose: firmware side of the register bus, an APB master
// Assumes: slave raises pready in the access phase
// Notes:   released paddr and pwdata show the caller's values inverted; pwrite drops to zero
`timescale 1ns/1ps
module uscr_fw_model (
   input  wire logic                    clk,
   output uscr_pkg::uscr_apb_req_t      apb_req,
   input  wire logic                    pready,
   input  wire logic                    pslverr,
   input  wire logic [31:0]             prdata
);
   import uscr_pkg::*;

   initial apb_req = '0;

   // ---------------------------------------------------------------
   // one transfer
   // ---------------------------------------------------------------
   // callers avoid false interrupts on polarity flips
   // soft wake only used as on a self-powered board
   // reserved bit 0 written as zero unless raw is asked
   task automatic xfer(input logic        wr,
                       input logic [9:0]  addr,
                       input logic [31:0] wdata,
                       input logic        raw,
                       output logic [31:0] rdata,
                       output logic       err);
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
                   pwdata: raw ? wdata : (wdata & 32'hFFFF_FFFE)};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      @(posedge clk);
      // no bound here: a dead slave ends in the bench watchdog
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      err = pslverr;
      apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: 1'b0,
                   paddr: ~addr, pwdata: ~wdata};
   endtask : xfer
endmodule : uscr_fw_model

//--- verif/tb.sv
// Purpose: self-checking bench of the system control block
// Assumes: random stimulus from a fixed seed
// Notes:   pulse counts assume the default active-low pin
`timescale 1ns/1ps
`include "uscr_params.svh"
module tb;
   import uscr_pkg::*;
   localparam logic [9:0] A_CTRL = {`USCR_CTRL_IDX, 2'b00};
   localparam logic [2:0] BAD [4] = '{3'b000, 3'b110, 3'b101, 3'b111};
   logic          clk, reset_n, pready, pslverr, err;
   uscr_apb_req_t req;
   logic [31:0]   prdata, rd;
   logic          susp, clk_run, feat, pwr_opt, low_out, rw_cmd;
   logic [3:0]    flags;
   logic          pin, dev_rst, rwe, wake_req, resume, rwf;
   logic [7:0]    c;
   int            n_fail = 0, n_compared = 0;
   int            n_act = 0, n_res = 0, n_rwf = 0, a0, r0;

   uscr_top u_dut (.clk(clk), .reset_n(reset_n), .apb_req(req),
      .apb_rsp_pready(pready), .apb_rsp_pslverr(pslverr),
      .apb_rsp_prdata(prdata), .suspended(susp),
      .clocks_running(clk_run), .feature_enable_bit(feat),
      .suspend_power_option(pwr_opt), .suspend_low_out_enable(low_out),
      .remote_wake_cmd(rw_cmd), .txrx_flag(flags[3]),
      .sof_flag(flags[2]), .bus_reset_flag(flags[1]),
      .suspend_flag(flags[0]), .interrupt_out_pin(pin),
      .device_reset(dev_rst), .remote_wake_enable(rwe),
      .wake_request(wake_req), .resume_signal(resume),
      .remote_wake_request_flag(rwf));
   uscr_fw_model u_fw (.clk(clk), .apb_req(req), .pready(pready),
      .pslverr(pslverr), .prdata(prdata));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (pin === 1'b0) n_act <= n_act + 1;
      if (resume === 1'b1) n_res <= n_res + 1;
      if (rwf === 1'b1) n_rwf <= n_rwf + 1;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_sig(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t signal %b expected %b", $time, got, exp);
      end
   endtask : chk_sig
   task automatic wr(input logic [7:0] d, input logic raw);
      u_fw.xfer(1'b1, A_CTRL, {24'h0, d}, raw, rd, err);
   endtask : wr
   task automatic rdc(input logic [7:0] e);
      u_fw.xfer(1'b0, A_CTRL, 32'h0, 1'b0, rd, err);
      chk_reg(rd, {24'h0, e});
   endtask : rdc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   function automatic logic exp_pin(logic [7:0] v, logic [3:0] f);
      logic a;
      a = v[`USCR_B_GIE] & (f[3] | f[2] | (v[`USCR_B_RIE] & f[1])
          | (v[`USCR_B_SIE] & f[0]));
      return v[`USCR_B_POL] ? a : ~a;
   endfunction : exp_pin
   task automatic print_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'hB8F9));
      {reset_n, susp, feat, pwr_opt, low_out, rw_cmd, flags} = '0;
      clk_run = 1'b1;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      chk_sig(pin, 1'b1);
      chk_sig(dev_rst, 1'b0);
      rdc(8'h00);
      u_fw.xfer(1'b1, 10'h3FC, 32'hFF, 1'b0, rd, err);
      chk_sig(err, 1'b1);
      rdc(8'h00);
      repeat (24) begin
         c = 8'($urandom) & 8'hF3; // soft reset, pulse mode kept off
         flags <= 4'($urandom);
         wr(c, 1'b1);
         cyc(3);
         chk_sig(rwe, c[`USCR_B_RWE]);
         chk_sig(pin, exp_pin(c, flags));
         rdc(c & 8'hFE);
      end
      flags <= 4'h0;
      wr(8'h06, 1'b0);
      cyc(3);
      a0 = n_act;
      flags <= 4'h8;
      cyc(8);
      chk_reg(32'(n_act - a0), 32'h2);
      wr(8'h02, 1'b0);
      cyc(2);
      a0 = n_act;
      cyc(8);
      chk_reg(32'(n_act - a0), 32'h8);
      flags <= 4'h0;
      wr(8'h08, 1'b0);
      cyc(2);
      chk_sig(dev_rst, 1'b1);
      rdc(8'h08);
      wr(8'h00, 1'b0);
      cyc(2);
      chk_sig(dev_rst, 1'b0);
      susp <= 1'b1;
      clk_run <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         {feat, pwr_opt, low_out} <= BAD[i];
         wr(8'h08, 1'b0);
         cyc(4);
         chk_sig(dev_rst, 1'b0);
         chk_sig(wake_req, 1'b0);
      end
      {feat, pwr_opt, low_out} <= 3'b100;
      r0 = n_res;
      a0 = n_rwf;
      wr(8'h08, 1'b0);
      cyc(3);
      chk_sig(wake_req, 1'b1);
      chk_sig(dev_rst, 1'b0);
      clk_run <= 1'b1;
      susp <= 1'b0;
      cyc(4);
      chk_sig(dev_rst, 1'b1);
      chk_reg(32'(n_res - r0), 32'h0);
      chk_reg(32'(n_rwf - a0), 32'h0);
      for (int e = 1; e >= 0; e--) begin
         wr(e ? 8'h40 : 8'h00, 1'b0);
         susp <= 1'b1;
         r0 = n_res;
         a0 = n_rwf;
         rw_cmd <= 1'b1;
         cyc(1);
         rw_cmd <= 1'b0;
         cyc(4);
         chk_reg(32'(n_res - r0), 32'(e));
         chk_reg(32'(n_rwf - a0), 32'(e));
      end
      // mid-run hard reset must clear a register with bits 7 to 4 and bit 1 set
      wr(8'hF2, 1'b0);
      reset_n <= 1'b0;
      cyc(2);
      chk_sig(rwe, 1'b0);
      chk_sig(pin, 1'b1);
      reset_n <= 1'b1;
      rdc(8'h00);
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
endmodule : tb
